// ---- gpio_defines.svh ----
// register indexes, reset values, control bits and timing counts of the gpio block
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define IDX_P1_IN       8'h00
`define IDX_P1_OUT      8'h01
`define IDX_P1_POL      8'h02
`define IDX_P1_DIR      8'h03
`define IDX_P1_STYLE    8'h04
`define IDX_P1_LATCH    8'h05
`define IDX_P2_IN       8'h08
`define IDX_P2_OUT      8'h09
`define IDX_P2_POL      8'h0A
`define IDX_P2_DIR      8'h0B
`define IDX_P2_STYLE    8'h0C
`define IDX_P2_LATCH    8'h0D
`define IDX_P1_STAT     8'h10
`define IDX_P2_STAT     8'h11
`define IDX_P1_IRQ_EN   8'h12
`define IDX_P2_IRQ_EN   8'h13
`define IDX_MODE        8'h14
`define IDX_LED         8'h15
`define IDX_ID_HIGH     8'h20
`define IDX_ID_LOW      8'h21

`define RST_OUT         8'h00
`define RST_P1_POL      8'hF0
`define RST_P1_DIR      8'hFF
`define RST_STYLE       8'h00
`define RST_P2_POL      8'h70
`define RST_P2_DIR      8'h7F
`define RST_ZERO        8'h00
`define P2_MASK         8'h7F
`define P2_IRQ_EN_MASK  8'h3F

`define MODE_LATCH_P1   0
`define MODE_LATCH_P2   1
`define MODE_PINRST_P1  2
`define MODE_PINRST_P2  3
`define MODE_INT_POL    4
`define MODE_INT_PULSE  5
`define MODE_INT_AT_P2  6
`define MODE_INT_ENABLE 7

`define SMB_ADDR_HIGH   4'h3

`define CLK_PERIOD_NS   8
`define GPO_PULSE_NS    1000
`define GPO_PULSE_CYCLES ((`GPO_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_PULSE_NS    1000
`define INT_PULSE_CYCLES ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- gpio_pkg.sv ----
// types shared by the gpio register block and its port slices
package gpio_pkg;

    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] polarity;
        logic [7:0] direction;
        logic [7:0] style;
    } port_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK   = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK  = 3'b110
    } smb_state_type;

endpackage

// ---- sync2.sv ----
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             ref_clk,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // no reset: the levels simply settle within two edges
    always_ff @(posedge ref_clk) begin
        meta_r   <= async_in;
        sync_out <= meta_r;
    end
endmodule

// ---- gpio_port.sv ----
// one gpio port: polarity, direction, level or pulse drive, transition detect
`timescale 1ns/1ns
`include "gpio_defines.svh"
module gpio_port (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // settings from the register file
    input  wire gpio_pkg::port_cfg_type cfg,
    input  wire logic [7:0]             pulse_fire,
    // synchronised pin levels
    input  wire logic [7:0]             pin_sync,
    // drive and read-back
    output logic      [7:0]             drive_val,
    output logic      [7:0]             drive_en,
    output logic      [7:0]             in_data,
    output logic      [7:0]             toggled
);
    import gpio_pkg::*;

    localparam logic [7:0] PULSE_LEN = 8'(`GPO_PULSE_CYCLES);

    logic [7:0] pin_d_r;
    logic [7:0] pulse_on;

    always_ff @(posedge ref_clk) begin
        pin_d_r <= pin_sync;
    end

    for (genvar i = 0; i < 8; i++) begin : g_pulse
        logic [7:0] cnt_r;
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt_r <= 8'h00;
            end else if (pulse_fire[i]) begin
                cnt_r <= PULSE_LEN;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
        assign pulse_on[i] = (cnt_r != 8'h00);
    end

    always_comb begin
        // pulse style ignores the stored bit, both during the pulse and after it
        drive_val = ((cfg.style & pulse_on) | (~cfg.style & cfg.out_data)) ^ cfg.polarity;
        drive_en  = ~cfg.direction;
        in_data   = pin_sync ^ cfg.polarity;
        toggled   = (pin_sync ^ pin_d_r) & cfg.direction;
    end
endmodule

// ---- smbus_gpio_port_registers.sv ----
// smbus register block for two gpio ports with latched inputs and transition interrupt
`timescale 1ns/1ns
`include "gpio_defines.svh"
module smbus_gpio_port_registers #(
    parameter logic [7:0] ID_HIGH        = 8'hA5,  // arbitrary value
    parameter logic [7:0] ID_LOW         = 8'h5A,  // arbitrary value
    parameter bit         TWO_ADDR_PINS  = 1'b0
) (
    // clock and power-on reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // external reset pin
    input  wire logic       rst_pin_n,
    // smbus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // port 1 pins
    input  wire logic [7:0] port1_pin_in,
    output logic      [7:0] port1_pin_out,
    output logic      [7:0] port1_pin_oe,
    // port 2 pins
    input  wire logic [6:0] port2_pin_in,
    output logic      [6:0] port2_pin_out,
    output logic      [6:0] port2_pin_oe
);
    import gpio_pkg::*;

    localparam logic [7:0] INT_LEN = 8'(`INT_PULSE_CYCLES);

    // synchronised pins
    logic [17:0] sync_bus;
    logic        scl_s;
    logic        sda_s;
    logic        rst_pin_n_s;
    logic [7:0]  p1_sync;
    logic [7:0]  p2_sync;

    sync2 #(.WIDTH(18)) u_sync (
        .ref_clk  (ref_clk),
        .async_in ({scl_in, sda_in, rst_pin_n, port1_pin_in, port2_pin_in}),
        .sync_out (sync_bus)
    );

    assign scl_s       = sync_bus[17];
    assign sda_s       = sync_bus[16];
    assign rst_pin_n_s = sync_bus[15];
    assign p1_sync     = sync_bus[14:7];
    assign p2_sync     = {1'b0, sync_bus[6:0]};

    // register state
    port_cfg_type p1_cfg_r;
    port_cfg_type p2_cfg_r;
    logic [7:0]   p1_latch_r;
    logic [7:0]   p2_latch_r;
    logic [7:0]   stat1_r;
    logic [7:0]   stat2_r;
    logic [7:0]   irq_en1_r;
    logic [7:0]   irq_en2_r;
    logic [7:0]   mode_r;
    logic [7:0]   led_r;

    // smbus engine state
    smb_state_type state_r;
    smb_state_type ack_next_r;
    logic [3:0]    bit_cnt_r;
    logic [7:0]    shift_r;
    logic [7:0]    index_r;
    logic          master_ack_r;
    logic          scl_d_r;
    logic          sda_d_r;
    logic          wr_stb_r;
    logic [7:0]    wr_idx_r;
    logic [7:0]    wr_dat_r;
    logic          rd_clr1_r;
    logic          rd_clr2_r;

    // port slice results
    logic [7:0] p1_drv;
    logic [7:0] p1_en;
    logic [7:0] p1_in;
    logic [7:0] p1_tog;
    logic [7:0] p2_drv;
    logic [7:0] p2_en;
    logic [7:0] p2_in;
    logic [7:0] p2_tog;
    logic [7:0] p1_fire;
    logic [7:0] p2_fire;

    function automatic logic [7:0] p2_bits(input logic [7:0] v);
        return v & `P2_MASK;
    endfunction

    function automatic logic is_write(input logic [7:0] idx);
        return wr_stb_r && (wr_idx_r == idx);
    endfunction

    // pulse starts only on a written 1 in pulse style
    assign p1_fire = is_write(`IDX_P1_OUT) ? (wr_dat_r & p1_cfg_r.style) : 8'h00;
    assign p2_fire = is_write(`IDX_P2_OUT) ? p2_bits(wr_dat_r & p2_cfg_r.style) : 8'h00;

    gpio_port u_port1 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .cfg        (p1_cfg_r),
        .pulse_fire (p1_fire),
        .pin_sync   (p1_sync),
        .drive_val  (p1_drv),
        .drive_en   (p1_en),
        .in_data    (p1_in),
        .toggled    (p1_tog)
    );

    gpio_port u_port2 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .cfg        (p2_cfg_r),
        .pulse_fire (p2_fire),
        .pin_sync   (p2_sync),
        .drive_val  (p2_drv),
        .drive_en   (p2_en),
        .in_data    (p2_in),
        .toggled    (p2_tog)
    );

    // slave address and events
    logic [6:0] own_addr;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       int_on_p1;
    logic       int_on_p2;
    logic [7:0] set1;
    logic [7:0] set2;
    logic       pin_rst1;
    logic       pin_rst2;

    assign own_addr  = {`SMB_ADDR_HIGH, p2_latch_r[2] & ~TWO_ADDR_PINS, p2_latch_r[1:0]};
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign int_on_p1 = mode_r[`MODE_INT_ENABLE] & ~mode_r[`MODE_INT_AT_P2];
    assign int_on_p2 = mode_r[`MODE_INT_ENABLE] & mode_r[`MODE_INT_AT_P2];
    // the pin carrying the interrupt never reports its own transitions
    assign set1      = p1_tog & ~{int_on_p1, 7'h00};
    assign set2      = p2_bits(p2_tog) & ~{1'b0, int_on_p2, 6'h00};
    assign pin_rst1  = ~rst_pin_n_s & mode_r[`MODE_PINRST_P1];
    assign pin_rst2  = ~rst_pin_n_s & mode_r[`MODE_PINRST_P2];

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        case (idx)
            `IDX_P1_IN:     return p1_in;
            `IDX_P1_OUT:    return p1_cfg_r.out_data;
            `IDX_P1_POL:    return p1_cfg_r.polarity;
            `IDX_P1_DIR:    return p1_cfg_r.direction;
            `IDX_P1_STYLE:  return p1_cfg_r.style;
            `IDX_P1_LATCH:  return p1_latch_r;
            `IDX_P2_IN:     return p2_bits(p2_in);
            `IDX_P2_OUT:    return p2_bits(p2_cfg_r.out_data);
            `IDX_P2_POL:    return p2_bits(p2_cfg_r.polarity);
            `IDX_P2_DIR:    return p2_bits(p2_cfg_r.direction);
            `IDX_P2_STYLE:  return p2_bits(p2_cfg_r.style);
            `IDX_P2_LATCH:  return p2_bits(p2_latch_r);
            `IDX_P1_STAT:   return stat1_r;
            `IDX_P2_STAT:   return stat2_r;
            `IDX_P1_IRQ_EN: return irq_en1_r;
            `IDX_P2_IRQ_EN: return irq_en2_r;
            `IDX_MODE:      return mode_r;
            `IDX_LED:       return led_r;
            `IDX_ID_HIGH:   return ID_HIGH;
            `IDX_ID_LOW:    return ID_LOW;
            default:        return 8'h00;
        endcase
    endfunction

    logic [7:0] rd_byte;
    assign rd_byte = read_reg(index_r);

    // smbus slave engine
    always_ff @(posedge ref_clk) begin
        scl_d_r <= scl_s;
        sda_d_r <= sda_s;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r      <= ST_IDLE;
            ack_next_r   <= ST_IDLE;
            bit_cnt_r    <= 4'h0;
            shift_r      <= 8'h00;
            index_r      <= 8'h00;
            master_ack_r <= 1'b0;
            sda_oe       <= 1'b0;
            wr_stb_r     <= 1'b0;
            wr_idx_r     <= 8'h00;
            wr_dat_r     <= 8'h00;
            rd_clr1_r    <= 1'b0;
            rd_clr2_r    <= 1'b0;
        end else begin
            wr_stb_r  <= 1'b0;
            rd_clr1_r <= 1'b0;
            rd_clr2_r <= 1'b0;
            if (bus_stop) begin
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
            end else if (bus_start) begin
                state_r   <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe    <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        if (scl_rise && bit_cnt_r != 4'h8) begin
                            shift_r   <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= ST_ACK;
                            sda_oe    <= 1'b1;
                            case (state_r)
                                ST_ADDR: begin
                                    if (shift_r[7:1] == own_addr) begin
                                        ack_next_r <= shift_r[0] ? ST_RDATA : ST_CMD;
                                    end else begin
                                        state_r <= ST_IDLE;
                                        sda_oe  <= 1'b0;
                                    end
                                end
                                ST_CMD: begin
                                    index_r    <= shift_r;
                                    ack_next_r <= ST_WDATA;
                                end
                                default: begin
                                    wr_stb_r   <= 1'b1;
                                    wr_idx_r   <= index_r;
                                    wr_dat_r   <= shift_r;
                                    ack_next_r <= ST_WDATA;
                                end
                            endcase
                        end
                    end
                    ST_ACK, ST_RACK: begin
                        if (scl_rise) begin
                            master_ack_r <= ~sda_s;
                        end else if (scl_fall) begin
                            if ((state_r == ST_ACK && ack_next_r == ST_RDATA) ||
                                (state_r == ST_RACK && master_ack_r)) begin
                                shift_r   <= {rd_byte[6:0], 1'b0};
                                sda_oe    <= ~rd_byte[7];
                                bit_cnt_r <= 4'h1;
                                state_r   <= ST_RDATA;
                                // a status read clears it, events that cycle survive
                                rd_clr1_r <= (index_r == `IDX_P1_STAT);
                                rd_clr2_r <= (index_r == `IDX_P2_STAT);
                            end else begin
                                sda_oe  <= 1'b0;
                                state_r <= (state_r == ST_ACK) ? ack_next_r : ST_IDLE;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                sda_oe  <= 1'b0;
                                state_r <= ST_RACK;
                            end else begin
                                sda_oe    <= ~shift_r[7];
                                shift_r   <= {shift_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // sda only ever pulls low
    always_ff @(posedge ref_clk) begin
        sda_out <= 1'b0;
    end

    // port 1 registers, optionally reset by the reset pin
    always_ff @(posedge ref_clk) begin
        if (rst || pin_rst1) begin
            p1_cfg_r.out_data  <= `RST_OUT;
            p1_cfg_r.polarity  <= `RST_P1_POL;
            p1_cfg_r.direction <= `RST_P1_DIR;
            p1_cfg_r.style     <= `RST_STYLE;
            irq_en1_r          <= `RST_ZERO;
        end else if (wr_stb_r) begin
            case (wr_idx_r)
                `IDX_P1_OUT:    p1_cfg_r.out_data  <= wr_dat_r;
                `IDX_P1_POL:    p1_cfg_r.polarity  <= wr_dat_r;
                `IDX_P1_DIR:    p1_cfg_r.direction <= wr_dat_r;
                `IDX_P1_STYLE:  p1_cfg_r.style     <= wr_dat_r;
                `IDX_P1_IRQ_EN: irq_en1_r          <= wr_dat_r;
                default: ;
            endcase
        end
    end

    // port 2 registers, bit 7 kept at zero
    always_ff @(posedge ref_clk) begin
        if (rst || pin_rst2) begin
            p2_cfg_r.out_data  <= `RST_OUT;
            p2_cfg_r.polarity  <= `RST_P2_POL;
            p2_cfg_r.direction <= `RST_P2_DIR;
            p2_cfg_r.style     <= `RST_STYLE;
            irq_en2_r          <= `RST_ZERO;
        end else if (wr_stb_r) begin
            case (wr_idx_r)
                `IDX_P2_OUT:    p2_cfg_r.out_data  <= p2_bits(wr_dat_r);
                `IDX_P2_POL:    p2_cfg_r.polarity  <= p2_bits(wr_dat_r);
                `IDX_P2_DIR:    p2_cfg_r.direction <= p2_bits(wr_dat_r);
                `IDX_P2_STYLE:  p2_cfg_r.style     <= p2_bits(wr_dat_r);
                `IDX_P2_IRQ_EN: irq_en2_r          <= wr_dat_r & `P2_IRQ_EN_MASK;
                default: ;
            endcase
        end
    end

    // mode and led registers, reset by power-on only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r <= `RST_ZERO;
            led_r  <= `RST_ZERO;
        end else if (is_write(`IDX_MODE)) begin
            mode_r <= wr_dat_r;
        end else if (is_write(`IDX_LED)) begin
            led_r <= wr_dat_r;
        end
    end

    // input snapshots: no reset value, they only follow the pins
    always_ff @(posedge ref_clk) begin
        if (rst || (~rst_pin_n_s && mode_r[`MODE_LATCH_P1])) begin
            p1_latch_r <= p1_sync;
        end
        if (rst || (~rst_pin_n_s && mode_r[`MODE_LATCH_P2])) begin
            p2_latch_r <= p2_sync;
        end
    end

    // transition status: set beats read-clear
    always_ff @(posedge ref_clk) begin
        if (rst || pin_rst1) begin
            stat1_r <= `RST_ZERO;
        end else begin
            // the pin carrying the interrupt keeps its status bit at zero
            stat1_r <= ((rd_clr1_r ? 8'h00 : stat1_r) | set1) & ~{int_on_p1, 7'h00};
        end
        if (rst || pin_rst2) begin
            stat2_r <= `RST_ZERO;
        end else begin
            stat2_r <= ((rd_clr2_r ? 8'h00 : stat2_r) | set2) & ~{1'b0, int_on_p2, 6'h00};
        end
    end

    // interrupt: level follows pending, pulse fires once per new pending
    logic       pend;
    logic       pend_d_r;
    logic [7:0] int_cnt_r;
    logic       int_act;
    logic       int_level;

    assign pend      = |(stat1_r & irq_en1_r) | |(stat2_r & irq_en2_r);
    assign int_act   = mode_r[`MODE_INT_PULSE] ? (int_cnt_r != 8'h00) : pend;
    assign int_level = mode_r[`MODE_INT_POL] ? ~int_act : int_act;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_d_r  <= 1'b0;
            int_cnt_r <= 8'h00;
        end else begin
            pend_d_r <= pend;
            if (pend && !pend_d_r) begin
                int_cnt_r <= INT_LEN;
            end else if (int_cnt_r != 8'h00) begin
                int_cnt_r <= int_cnt_r - 8'h01;
            end
        end
    end

    // pin drive stage; interrupt takes over its pin when enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port1_pin_out <= 8'h00;
            port1_pin_oe  <= 8'h00;
            port2_pin_out <= 7'h00;
            port2_pin_oe  <= 7'h00;
        end else begin
            port1_pin_out <= p1_drv;
            port1_pin_oe  <= p1_en;
            port2_pin_out <= p2_drv[6:0];
            port2_pin_oe  <= p2_en[6:0];
            if (int_on_p1) begin
                port1_pin_out[7] <= int_level;
                port1_pin_oe[7]  <= 1'b1;
            end
            if (int_on_p2) begin
                port2_pin_out[6] <= int_level;
                port2_pin_oe[6]  <= 1'b1;
            end
        end
    end
endmodule

// ---- gpio_checker_assertions.sv ----
// pin-level checks of the gpio register block
`timescale 1ns/1ns
module gpio_checker (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       rst_pin_n,
    // smbus
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // pins
    input wire logic [7:0] port1_pin_out,
    input wire logic [7:0] port1_pin_oe,
    input wire logic [6:0] port2_pin_out,
    input wire logic [6:0] port2_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    a_sda_never_high: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    a_p1_reset_idle: assert property (disable iff (1'b0)
        rst |=> (port1_pin_oe | port1_pin_out) == 8'h00) else $error("port1 active in reset");
    a_p2_reset_idle: assert property (disable iff (1'b0)
        rst |=> (port2_pin_oe | port2_pin_out) == 7'h00) else $error("port2 active in reset");
    a_sda_reset_free: assert property (disable iff (1'b0) rst |=> !sda_oe)
        else $error("sda pulled in reset");
    a_hold_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    a_ack_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("sda pulled too early");
    a_stop_release: assert property (stop_seen |=> (!sda_oe) [*8])
        else $error("sda pulled after stop");
    // a reset pin pulse may restore the directions at any time
    a_dir_on_write: assert property ($changed(port1_pin_oe) || $changed(port2_pin_oe) |->
        !scl_in || !$past(rst_pin_n, 3))
        else $error("direction moved outside a write");
endmodule

bind smbus_gpio_port_registers gpio_checker chk (.ref_clk, .rst, .rst_pin_n, .scl_in, .sda_in, .sda_out,
    .sda_oe, .port1_pin_out, .port1_pin_oe, .port2_pin_out, .port2_pin_oe);

// ---- smbus_host_model.sv ----
// smbus host model issuing byte writes and byte reads
`timescale 1ns/1ns
module smbus_host (
    // clock
    input  wire logic ref_clk,
    // device pull on data
    input  wire logic sda_oe,
    // bus levels
    output logic      scl,
    output logic      sda
);
    logic       sda_r = 1'b1;
    logic [2:0] acks  = 3'h0;
    // pulled-up wire, low while either side pulls
    assign sda = sda_r & ~sda_oe;
    initial scl = 1'b1;
    task automatic half();
        repeat (8) @(posedge ref_clk);
    endtask
    // data moves one edge after scl fell, never beside it
    task automatic clk_bit(input logic b, output logic r);
        @(posedge ref_clk);
        sda_r <= b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic cond(input logic a, input logic b);
        @(posedge ref_clk);
        sda_r <= a;
        half();
        scl <= 1'b1;
        half();
        sda_r <= b;
        half();
    endtask
    task automatic start();
        cond(1'b1, 1'b0);
        scl <= 1'b0;
    endtask
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        acks = {acks[1:0], !r};
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d);
        start();
        send({a, 1'b0});
        send(idx);
        send(d);
        cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d);
        logic r;
        start();
        send({a, 1'b0});
        send(idx);
        start();
        send({a, 1'b1});
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b1, r);
        cond(1'b0, 1'b1);
    endtask
endmodule

// ---- smbus_gpio_port_registers_test.sv ----
// self-checking bench for the smbus gpio register block
`timescale 1ns/1ns
module smbus_gpio_port_registers_test;
    localparam logic [6:0] DEV  = 7'h1D;
    localparam logic [7:0] ID_H = 8'h3E;  // arbitrary value
    localparam logic [7:0] ID_L = 8'hC1;  // arbitrary value
    localparam logic [7:0] DF1 [4] = '{8'h00, 8'hF0, 8'hFF, 8'h00};
    localparam logic [7:0] DF2 [4] = '{8'h00, 8'h70, 8'h7F, 8'h00};
    logic       ref_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       rst_pin_n = 1'b1;
    logic [7:0] p1_ext    = 8'h3C;
    logic [6:0] p2_ext    = 7'h05;
    logic       scl, sda, sda_oe;
    logic [7:0] p1_out, p1_oe, p1_in, v;
    logic [6:0] p2_out, p2_oe, p2_in;
    int         n_fail    = 0;
    int         checked   = 0;
    always #4 ref_clk = ~ref_clk;
    // output pins read back their own drive
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
    assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_ext);
    smbus_host host (.ref_clk, .sda_oe, .scl, .sda);
    smbus_gpio_port_registers #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) uut (.ref_clk, .rst, .rst_pin_n,
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .port1_pin_in(p1_in),
        .port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .port2_pin_in(p2_in),
        .port2_pin_out(p2_out), .port2_pin_oe(p2_oe));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        host.rd(DEV, idx, v);
        check($sformatf("index %h", idx), v, exp);
        check("ack", {5'h00, host.acks}, 8'h07);
    endtask
    task automatic pin_reset();
        rst_pin_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_pin_n <= 1'b1;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        foreach (DF1[i]) rd_chk(8'h01 + 8'(i), DF1[i]);
        foreach (DF2[i]) rd_chk(8'h09 + 8'(i), DF2[i]);
        rd_chk(8'h20, ID_H);
        rd_chk(8'h21, ID_L);
        rd_chk(8'h0D, 8'h05);
        p1_ext <= 8'hA5;
        p2_ext <= 7'h2A;
        rd_chk(8'h05, 8'h3C);
        rd_chk(8'h00, 8'h55);
        rd_chk(8'h08, 8'h5A);
        host.wr(DEV, 8'h14, 8'h01);
        pin_reset();
        rd_chk(8'h05, 8'hA5);
        rd_chk(8'h0D, 8'h05);
        host.wr(DEV, 8'h06, 8'hFF);
        host.wr(DEV, 8'h20, 8'h00);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h20, ID_H);
        host.wr(DEV ^ 7'h04, 8'h09, 8'h7F);
        check("foreign ack", {5'h00, host.acks}, 8'h00);
        host.wr(DEV, 8'h01, 8'hC3);
        host.wr(DEV, 8'h02, 8'h00);
        host.wr(DEV, 8'h03, 8'h0F);
        check("p1 oe", p1_oe, 8'hF0);
        check("p1 level", p1_out & p1_oe, 8'hC0);
        rd_chk(8'h00, 8'hC5);
        host.wr(DEV, 8'h02, 8'hF0);
        check("p1 inverted", p1_out & p1_oe, 8'h30);
        rd_chk(8'h01, 8'hC3);
        host.wr(DEV, 8'h0C, 8'h01);
        host.wr(DEV, 8'h0A, 8'h00);
        host.wr(DEV, 8'h0B, 8'h7E);
        check("p2 oe", {1'b0, p2_oe}, 8'h01);
        host.wr(DEV, 8'h09, 8'h81);
        check("pulse on", {7'h00, p2_out[0]}, 8'h01);
        repeat (125) @(posedge ref_clk);
        check("pulse off", {7'h00, p2_out[0]}, 8'h00);
        rd_chk(8'h09, 8'h01);
        host.wr(DEV, 8'h12, 8'h0F);
        host.wr(DEV, 8'h14, 8'h80);
        check("int level", {6'h00, p1_oe[7], p1_out[7]}, 8'h03);
        rd_chk(8'h10, 8'h19);
        check("int cleared", {6'h00, p1_oe[7], p1_out[7]}, 8'h02);
        p1_ext <= 8'hA7;
        repeat (8) @(posedge ref_clk);
        check("int again", {6'h00, p1_oe[7], p1_out[7]}, 8'h03);
        host.wr(DEV, 8'h14, 8'h90);
        check("int low", {6'h00, p1_oe[7], p1_out[7]}, 8'h02);
        rd_chk(8'h10, 8'h02);
        check("int idle high", {6'h00, p1_oe[7], p1_out[7]}, 8'h03);
        host.wr(DEV, 8'h14, 8'h04);
        host.wr(DEV, 8'h05, 8'h00);
        pin_reset();
        check("p1 oe reset", p1_oe, 8'h00);
        rd_chk(8'h03, 8'hFF);
        rd_chk(8'h05, 8'hA5);
        report_and_stop();
    end
endmodule
